// [rtl/icr_map.svh]
// port indices, command fields, port B bits and tick timing for the interval counters
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

`define ICR_IDX_CNT0     8'h40
`define ICR_IDX_CNT2     8'h42
`define ICR_IDX_CTRL     8'h43
`define ICR_IDX_PORTB    8'h61

`define ICR_CW_SEL       7:6
`define ICR_CW_FMT       5:4
`define ICR_CW_MODE      3:1
`define ICR_CW_BCD       0
`define ICR_SEL_C0       2'h0
`define ICR_SEL_C2       2'h2
`define ICR_SEL_RB       2'h3
`define ICR_RB_NCNT      5
`define ICR_RB_NSTS      4
`define ICR_RB_C0        1
`define ICR_RB_C2        3

`define ICR_PB_GATE      0
`define ICR_PB_SPK       1
`define ICR_PB_OUT2      5

`define ICR_RST_COUNT    16'h0000
`define ICR_RST_MODE     3'h0
`define ICR_CLK_KHZ      125000
`define ICR_TICK_KHZ     1193
`define ICR_TICK_DIV     (`ICR_CLK_KHZ / `ICR_TICK_KHZ)

`endif

// [rtl/icr_pkg.sv]
// types shared by the interval counter read path
package icr_pkg;
  typedef logic [2:0] icr_mode_t;
  typedef enum logic [1:0] {ICR_FMT_LATCH, ICR_FMT_LSB, ICR_FMT_MSB, ICR_FMT_WORD} icr_fmt_t;
endpackage

// [rtl/icr_counter.sv]
// one count-down channel with mode-dependent output and pending-load tracking
`timescale 1ns/1ns
`include "icr_map.svh"
module icr_counter (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          gate,
  input  wire logic          cfg_we,
  input  icr_pkg::icr_mode_t mode_in,
  input  wire logic          bcd_in,
  input  wire logic          cnt_we,
  input  wire logic [15:0]   cnt_in,
  output logic [15:0]        count_r,
  output logic               out_r,
  output logic               null_r,
  output icr_pkg::icr_mode_t mode_r,
  output logic               bcd_r
);
  import icr_pkg::*;

  logic [15:0] init_r;
  logic        pend_r;
  logic [15:0] nxt;
  logic        term;
  icr_mode_t   mode_norm;

  function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v - 16'h0001;
    borrow = 1'b1;
    if (bcd)
    begin
      r = v;
      for (int i = 0; i < 4; i++)
      begin
        if (borrow)
        begin
          if (v[i*4 +: 4] == 4'h0)
            r[i*4 +: 4] = 4'h9;
          else
          begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // modes 6 and 7 alias rate generator and square wave
  always_comb
  begin
    mode_norm = (mode_in[2:1] == 2'h3) ? {1'b0, mode_in[1:0]} : mode_in;
    nxt       = dec1(count_r, bcd_r);
    if (mode_r == 3'h3)
      nxt = dec1(nxt, bcd_r);
    term = (count_r == 16'h0001) || (mode_r == 3'h3 && count_r == 16'h0002);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= `ICR_RST_COUNT;
      init_r  <= `ICR_RST_COUNT;
      pend_r  <= 1'b0;
      out_r   <= 1'b0;
      null_r  <= 1'b0;
      mode_r  <= `ICR_RST_MODE;
      bcd_r   <= 1'b0;
    end
    else if (cfg_we)
    begin
      mode_r <= mode_norm;
      bcd_r  <= bcd_in;
      out_r  <= (mode_norm != 3'h0);
      null_r <= 1'b1;
      pend_r <= 1'b0;
    end
    else if (cnt_we)
    begin
      // the new count is taken at the next tick, so pending-load shows meanwhile
      init_r <= cnt_in;
      pend_r <= 1'b1;
      null_r <= 1'b1;
      if (mode_r == 3'h0)
        out_r <= 1'b0;
    end
    // a pending count still loads while gated; the gate only stops the countdown
    else if (tick && (gate || pend_r))
    begin
      if (pend_r)
      begin
        count_r <= init_r;
        pend_r  <= 1'b0;
        null_r  <= 1'b0;
      end
      else if (term)
      begin
        case (mode_r)
          3'h0:
          begin
            out_r   <= 1'b1;
            count_r <= nxt;
          end
          3'h2:
          begin
            out_r   <= 1'b1;
            count_r <= init_r;
          end
          3'h3:
          begin
            out_r   <= ~out_r;
            count_r <= init_r;
          end
          default:
          begin
            out_r   <= 1'b0;
            count_r <= nxt;
          end
        endcase
      end
      else
      begin
        count_r <= nxt;
        if (mode_r == 3'h2 && nxt == 16'h0001)
          out_r <= 1'b0;
        else if (mode_r != 3'h0 && mode_r != 3'h3)
          out_r <= 1'b1;
      end
    end
  end
endmodule

// [rtl/icr_top.sv]
// interval counter read path: AHB-Lite port map, latch and read-back logic, two counters
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "icr_map.svh"
// Overview of operation
// - plain reads served at ports 40h, 42h
// - gate bit at 61h halts counter two
// - latch command captures current count, counting continues
// - latch held until read or reprogrammed
// - latching never alters mode or format
// - second latch before read is ignored
// - read-back captures count plus status word
// - read-back latches several, each released separately
// - repeated read-back count latches are ignored
// - repeated status latches are ignored
// - status read from counter's own port
// - combined read-back equals two separate commands
// - status first, then latched count bytes
// - after both consumed, reads follow live count
// - control word sets mode and format
// - counters decrement on slow periodic tick
module icr_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq0,
  output logic             spkr
);
  import icr_pkg::*;

  logic              tick_r;
  logic [7:0]        div_r;
  logic              gate_r;
  logic              spk_en_r;
  logic              wr_pend_r;
  logic [7:0]        wr_idx_r;
  logic [7:0]        wd;
  logic              ap;
  logic              ap_rd;
  logic [7:0]        ap_idx;
  logic [7:0]        rd_byte;
  icr_fmt_t          fmt_r    [2];
  logic [15:0]       cnt_lat_r[2];
  logic [7:0]        sts_lat_r[2];
  logic [1:0]        cnt_v_r;
  logic [1:0]        sts_v_r;
  logic [1:0]        rd_hi_r;
  logic [1:0]        wr_hi_r;
  logic [7:0]        wr_lo_r  [2];
  logic [15:0]       live     [2];
  logic [1:0]        out_c;
  logic [1:0]        null_c;
  icr_mode_t         mode_c   [2];
  logic [1:0]        bcd_c;
  logic [1:0]        gate_c;
  logic [1:0]        ctl_we;
  logic [1:0]        cnt_req;
  logic [1:0]        sts_req;
  logic [1:0]        rd;
  logic [1:0]        cnt_we;
  logic [15:0]       cnt_val  [2];
  logic [7:0]        status   [2];
  logic [7:0]        rd_val   [2];

  function automatic logic [7:0] port_of(input int c);
    return (c == 0) ? `ICR_IDX_CNT0 : `ICR_IDX_CNT2;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] v, input icr_fmt_t f,
                                           input logic hi);
    if (f == ICR_FMT_MSB || (f == ICR_FMT_WORD && hi))
      return v[15:8];
    return v[7:0];
  endfunction

  // the tick is a divided-down strobe of the bus clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else if (div_r == 8'(`ICR_TICK_DIV - 1))
    begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  assign gate_c = {gate_r, 1'b1};

  for (genvar g = 0; g < 2; g++)
  begin : g_cnt
    icr_counter u_cnt (
      .clk     (hclk),
      .rst_n   (hresetn),
      .tick    (tick_r),
      .gate    (gate_c[g]),
      .cfg_we  (ctl_we[g]),
      .mode_in (wd[`ICR_CW_MODE]),
      .bcd_in  (wd[`ICR_CW_BCD]),
      .cnt_we  (cnt_we[g]),
      .cnt_in  (cnt_val[g]),
      .count_r (live[g]),
      .out_r   (out_c[g]),
      .null_r  (null_c[g]),
      .mode_r  (mode_c[g]),
      .bcd_r   (bcd_c[g])
    );
  end

  assign ap     = hsel && hready && htrans[1];
  assign ap_rd  = ap && !hwrite && (haddr[31:10] == 22'h0);
  assign ap_idx = haddr[9:2];
  assign wd     = hwdata[7:0];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      logic sel;
      logic rbs;
      logic cw;
      sel        = wd[`ICR_CW_SEL] == ((c == 0) ? `ICR_SEL_C0 : `ICR_SEL_C2);
      rbs        = wd[(c == 0) ? `ICR_RB_C0 : `ICR_RB_C2];
      cw         = wr_pend_r && wr_idx_r == `ICR_IDX_CTRL;
      ctl_we[c]  = cw && sel && wd[`ICR_CW_FMT] != 2'h0;
      // a combined read-back simply raises both requests
      cnt_req[c] = cw && ((sel && wd[`ICR_CW_FMT] == 2'h0)
                   || (wd[`ICR_CW_SEL] == `ICR_SEL_RB && !wd[`ICR_RB_NCNT] && rbs));
      sts_req[c] = cw && wd[`ICR_CW_SEL] == `ICR_SEL_RB && !wd[`ICR_RB_NSTS] && rbs;
      rd[c]      = ap_rd && ap_idx == port_of(c);
      cnt_we[c]  = wr_pend_r && wr_idx_r == port_of(c)
                   && (fmt_r[c] != ICR_FMT_WORD || wr_hi_r[c]);
      if (fmt_r[c] == ICR_FMT_MSB)
        cnt_val[c] = {wd, 8'h00};
      else if (fmt_r[c] == ICR_FMT_WORD)
        cnt_val[c] = {wd, wr_lo_r[c]};
      else
        cnt_val[c] = {8'h00, wd};
      status[c]  = {out_c[c], null_c[c], fmt_r[c], mode_c[c], bcd_c[c]};
      rd_val[c]  = sts_v_r[c] ? sts_lat_r[c]
                   : pick_byte(cnt_v_r[c] ? cnt_lat_r[c] : live[c], fmt_r[c], rd_hi_r[c]);
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (ap_idx == `ICR_IDX_CNT0)
      rd_byte = rd_val[0];
    else if (ap_idx == `ICR_IDX_CNT2)
      rd_byte = rd_val[1];
    else if (ap_idx == `ICR_IDX_PORTB)
    begin
      rd_byte[`ICR_PB_OUT2] = out_c[1];
      rd_byte[`ICR_PB_SPK]  = spk_en_r;
      rd_byte[`ICR_PB_GATE] = gate_r;
    end
  end

  // zero-wait slave: read data is formed in the address phase so read side effects
  // and the returned byte come from the same state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= ap && hwrite && (haddr[31:10] == 22'h0);
      wr_idx_r  <= ap_idx;
      if (ap_rd)
        hrdata <= {24'h0, rd_byte};
      else if (ap)
        hrdata <= 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_r   <= 1'b0;
      spk_en_r <= 1'b0;
      irq0     <= 1'b0;
      spkr     <= 1'b0;
    end
    else
    begin
      if (wr_pend_r && wr_idx_r == `ICR_IDX_PORTB)
      begin
        gate_r   <= wd[`ICR_PB_GATE];
        spk_en_r <= wd[`ICR_PB_SPK];
      end
      irq0 <= out_c[0];
      spkr <= out_c[1] && spk_en_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        fmt_r[c]   <= ICR_FMT_LSB;
        wr_lo_r[c] <= 8'h00;
      end
      wr_hi_r <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (ctl_we[c])
        begin
          fmt_r[c]   <= icr_fmt_t'(wd[`ICR_CW_FMT]);
          wr_hi_r[c] <= 1'b0;
        end
        else if (wr_pend_r && wr_idx_r == port_of(c) && fmt_r[c] == ICR_FMT_WORD)
        begin
          wr_hi_r[c] <= ~wr_hi_r[c];
          wr_lo_r[c] <= wd;
        end
      end
    end
  end

  // a capture request in the same cycle as a consuming read is ignored, since the latch still counts as held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        cnt_lat_r[c] <= `ICR_RST_COUNT;
        sts_lat_r[c] <= 8'h00;
      end
      cnt_v_r <= 2'h0;
      sts_v_r <= 2'h0;
      rd_hi_r <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (ctl_we[c])
        begin
          cnt_v_r[c] <= 1'b0;
          sts_v_r[c] <= 1'b0;
          rd_hi_r[c] <= 1'b0;
        end
        else
        begin
          if (rd[c] && sts_v_r[c])
            sts_v_r[c] <= 1'b0;
          else if (rd[c])
          begin
            if (fmt_r[c] == ICR_FMT_WORD)
              rd_hi_r[c] <= ~rd_hi_r[c];
            if (fmt_r[c] != ICR_FMT_WORD || rd_hi_r[c])
              cnt_v_r[c] <= 1'b0;
          end
          if (cnt_req[c] && !cnt_v_r[c])
          begin
            cnt_lat_r[c] <= live[c];
            cnt_v_r[c]   <= 1'b1;
          end
          if (sts_req[c] && !sts_v_r[c])
          begin
            sts_lat_r[c] <= status[c];
            sts_v_r[c]   <= 1'b1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_latch_capture;
    cnt_req[0] && !cnt_v_r[0] && !ctl_we[0] |=> cnt_v_r[0] && cnt_lat_r[0] == $past(live[0]);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("count latch missed");

  property p_latch_ignore;
    cnt_req[1] && cnt_v_r[1] && !rd[1] && !ctl_we[1] |=> $stable(cnt_lat_r[1]) && cnt_v_r[1];
  endproperty
  a_latch_ignore: assert property (p_latch_ignore) else $error("relatch overwrote count");

  property p_rb_multi;
    rd[0] && cnt_v_r[1] && !ctl_we[1] |=> cnt_v_r[1];
  endproperty
  a_rb_multi: assert property (p_rb_multi) else $error("other counter released");

  property p_sts_ignore;
    sts_req[0] && sts_v_r[0] && !rd[0] && !ctl_we[0] |=> $stable(sts_lat_r[0]);
  endproperty
  a_sts_ignore: assert property (p_sts_ignore) else $error("status relatch overwrote");

  sequence s_rd_sts;
    rd[0] && sts_v_r[0] && cnt_v_r[0] && !ctl_we[0] && !cnt_req[0] && !sts_req[0];
  endsequence
  sequence s_sts_given;
    hrdata[7:0] == $past(sts_lat_r[0]) && cnt_v_r[0] && !sts_v_r[0];
  endsequence
  property p_status_first;
    s_rd_sts |=> s_sts_given;
  endproperty
  a_status_first: assert property (p_status_first) else $error("status not first");

  property p_unlatched;
    rd[0] && !sts_v_r[0] && !cnt_v_r[0] && fmt_r[0] == ICR_FMT_LSB
      |=> hrdata[7:0] == $past(live[0][7:0]);
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("live read wrong");

  property p_release;
    ctl_we[1] |=> !cnt_v_r[1] && !sts_v_r[1];
  endproperty
  a_release: assert property (p_release) else $error("latch kept after reprogram");

  property p_mode_kept;
    cnt_req[0] && !ctl_we[0] |=> $stable(fmt_r[0]) && $stable(mode_c[0]);
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("latch changed mode");

  property p_gate_halt;
    !gate_r && !(tick_r && null_c[1]) && !cnt_we[1] && !ctl_we[1] |=> $stable(live[1]);
  endproperty
  a_gate_halt: assert property (p_gate_halt) else $error("gated counter moved");

  property p_tick_gap;
    tick_r |=> !tick_r [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too fast");

  property p_word_order;
    rd[0] && !sts_v_r[0] && cnt_v_r[0] && fmt_r[0] == ICR_FMT_WORD && !rd_hi_r[0]
      && !ctl_we[0] |=> hrdata[7:0] == $past(cnt_lat_r[0][7:0]) && cnt_v_r[0] && rd_hi_r[0];
  endproperty
  a_word_order: assert property (p_word_order) else $error("low byte not first");

  property p_combo;
    cnt_req[1] && sts_req[1] && !cnt_v_r[1] && !sts_v_r[1] |=> cnt_v_r[1] && sts_v_r[1];
  endproperty
  a_combo: assert property (p_combo) else $error("combined read-back incomplete");
endmodule

// [testbench/icr_host_model.sv]
// host model: byte-wide port reads and writes issued as single AHB-Lite transfers
`timescale 1ns/1ns
module icr_host_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // each phase is held until hready is sampled high; read data is taken at that edge
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    // a read data phase carries no write data, so the bus shows a changing pattern
    hwdata <= wr ? {24'h0, wd} : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    rd = hrdata[7:0];
  endtask

  task automatic io_wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] unused;
    xfer(idx, 1'b1, wd, unused);
  endtask

  // two-byte counts are fetched as two of these, other ports may come between
  task automatic io_rd(input logic [7:0] idx, output logic [7:0] rd);
    xfer(idx, 1'b0, 8'h00, rd);
  endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for plain, latched and read-back counter reads
`timescale 1ns/1ns
`include "icr_map.svh"
module tb_top;
  import icr_pkg::*;
  localparam int TICK = `ICR_TICK_DIV;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq0;
  logic        spkr;
  logic [7:0]  b;
  logic [15:0] n;
  logic [15:0] a;
  logic [15:0] v;
  logic [1:0]  fmt;
  logic        bcd;
  integer      seed;
  int          err_count;
  int          n_tests;

  icr_top u_icr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq0(irq0), .spkr(spkr));

  icr_host_model u_icr_host_model (.hclk(hclk), .hresetn(hresetn), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // value a read returns for a count written in the given byte format
  function automatic logic [15:0] exp_cnt(input logic [1:0] f, input logic [15:0] c);
    case (f)
      2'h1:    exp_cnt = {8'h00, c[7:0]};
      2'h2:    exp_cnt = {c[15:8], 8'h00};
      default: exp_cnt = c;
    endcase
  endfunction

  task automatic wr_cnt(input logic [7:0] idx, input logic [1:0] f, input logic [15:0] c);
    if (f != 2'h2)
      u_icr_host_model.io_wr(idx, c[7:0]);
    if (f != 2'h1)
      u_icr_host_model.io_wr(idx, c[15:8]);
  endtask

  task automatic rd_cnt(input logic [7:0] idx, input logic [1:0] f, output logic [15:0] c);
    logic [7:0] t;
    c = 16'h0;
    if (f != 2'h2)
    begin
      u_icr_host_model.io_rd(idx, t);
      c[7:0] = t;
    end
    if (f != 2'h1)
    begin
      u_icr_host_model.io_rd(idx, t);
      c[15:8] = t;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    test_done;
  end

  initial
  begin
    seed = 80;
    err_count = 0;
    n_tests = 0;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_cnt(`ICR_IDX_CNT2, 2'h1, v);
    chk("c2_reset", v, 16'h0);
    u_icr_host_model.io_rd(`ICR_IDX_CTRL, b);
    chk("ctrl_read", {8'h0, b}, 16'h0);
    u_icr_host_model.io_rd(8'h50, b);
    chk("unmapped", {8'h0, b}, 16'h0);
    // counter two stays halted (gate low), so every read is exactly predictable
    for (int m = 0; m < 6; m++)
    begin
      fmt = 2'(m % 3 + 1);
      bcd = m[0];
      n = (16'($random(seed)) & (bcd ? 16'h7777 : 16'hffff)) | 16'h0101;
      // old count latched here must be dropped by the reprogramming below
      u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h80);
      u_icr_host_model.io_wr(`ICR_IDX_CTRL, {2'h2, fmt, m[2:0], bcd});
      wr_cnt(`ICR_IDX_CNT2, fmt, n);
      repeat (2 * TICK + 20) @(posedge hclk);
      u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'hc8);
      u_icr_host_model.io_rd(`ICR_IDX_CNT2, b);
      chk("c2_status", {8'h0, b}, {8'h0, (m != 0), 1'b0, fmt, m[2:0], bcd});
      rd_cnt(`ICR_IDX_CNT2, fmt, v);
      chk("c2_latched", v, exp_cnt(fmt, n));
      rd_cnt(`ICR_IDX_CNT2, fmt, v);
      chk("c2_live", v, exp_cnt(fmt, n));
    end
    // counter zero runs freely; status latched while the new count is still pending
    n = 16'($random(seed)) | 16'h8000;
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h30);
    wr_cnt(`ICR_IDX_CNT0, 2'h3, n);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'he2);
    repeat (2 * TICK + 20) @(posedge hclk);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'he2);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'hd2);
    repeat (5 * TICK) @(posedge hclk);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h00);
    u_icr_host_model.io_rd(`ICR_IDX_CNT0, b);
    chk("c0_status", {8'h0, b}, 16'h0070);
    rd_cnt(`ICR_IDX_CNT0, 2'h3, a);
    chk("c0_capture", {15'h0, (n - a) <= 16'd4}, 16'h1);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h00);
    rd_cnt(`ICR_IDX_CNT0, 2'h3, v);
    chk("c0_ticks", {15'h0, (a - v) >= 16'd4 && (a - v) <= 16'd7}, 16'h1);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'he2);
    u_icr_host_model.io_rd(`ICR_IDX_CNT0, b);
    chk("c0_mode", {8'h0, b}, 16'h0030);
    // one command latches both counters; reading one leaves the other held
    n = 16'($random(seed)) | 16'h8000;
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'hb0);
    wr_cnt(`ICR_IDX_CNT2, 2'h3, n);
    repeat (2 * TICK + 20) @(posedge hclk);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'hda);
    u_icr_host_model.io_wr(`ICR_IDX_PORTB, 8'h03);
    repeat (5 * TICK) @(posedge hclk);
    // counter two still holds its capture, so this latch command must be ignored
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h80);
    rd_cnt(`ICR_IDX_CNT0, 2'h3, v);
    rd_cnt(`ICR_IDX_CNT2, 2'h3, v);
    chk("c2_held", v, n);
    rd_cnt(`ICR_IDX_CNT2, 2'h3, v);
    chk("c2_runs", {15'h0, (n - v) >= 16'd3 && (n - v) <= 16'd8}, 16'h1);
    // short counts reach terminal count; select 01 names no counter and must not disturb
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h10);
    u_icr_host_model.io_wr(`ICR_IDX_CNT0, 8'h02);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h90);
    u_icr_host_model.io_wr(`ICR_IDX_CNT2, 8'h02);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h50);
    repeat (4 * TICK) @(posedge hclk);
    u_icr_host_model.io_rd(`ICR_IDX_CNT0, b);
    u_icr_host_model.io_rd(`ICR_IDX_PORTB, b);
    chk("portb", {8'h0, b}, 16'h0023);
    chk("irq0", {15'h0, irq0}, 16'h0001);
    chk("spkr", {15'h0, spkr}, 16'h0001);
    chk("hresp", {15'h0, hresp}, 16'h0000);
    // mode 6 is stored as its alias, mode 2, which drives the output high at once
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'h9c);
    u_icr_host_model.io_wr(`ICR_IDX_CTRL, 8'he8);
    u_icr_host_model.io_rd(`ICR_IDX_CNT2, b);
    chk("c2_alias", {8'h0, b}, 16'h00d4);
    test_done;
  end
endmodule
